// File: rtl/pa_defines.svh
/*
  Constants for the shared pin 10 function select of port A.
  Assumes inclusion by the package and the design modules.
*/
`ifndef PA_DEFINES_SVH
`define PA_DEFINES_SVH

`define PA_ADDR_W      3
`define PA_DATA_W      16
`define PA_ADDR_CTRL1  3'h0
`define PA_ADDR_CTRL3  3'h1
`define PA_ADDR_PDATA  3'h2
`define PA_ADDR_PDIR   3'h3
`define PA_ADDR_STAT   3'h4

`define PA_MD_HI_BIT   10
`define PA_MD_LO_MSB   5
`define PA_MD_LO_LSB   4
`define PA_PBIT        0
`define PA_ST_LVL      0
`define PA_ST_MD_LSB   1
`define PA_ST_MD_MSB   3

`define PA_MODE_PORT   3'h0
`define PA_MODE_CS0    3'h1
`define PA_MODE_RD     3'h2
`define PA_MODE_TCK    3'h4
`define PA_MODE_SERIAL_CH2_CLOCK   3'h5

`define PA_RST_REG     16'h0000
`define PA_RST_SYNC    3'h0

`endif

// File: rtl/pa_pkg.sv
/*
  Types for the shared pin 10 function select of port A.
  Assumes pa_defines.svh is on the include path.
*/
`include "pa_defines.svh"

package pa_pkg;

  typedef logic [2:0] pa_mode_t;

  typedef struct packed {
    logic [`PA_DATA_W-1:0] ctrl1;
    logic [`PA_DATA_W-1:0] ctrl3;
    logic                  port_do;
    logic                  port_dir;
    logic [2:0]            sync;
    logic                  pin_f;
    logic [`PA_DATA_W-1:0] rdata;
    logic                  tck;
    logic                  sck_in;
  } pa_top_st_t;

  typedef struct packed {
    logic pin_do;
    logic pin_oe_n;
  } pa_mux_st_t;

endpackage

// File: rtl/pa_mux_if.sv
/*
  Carrier between the register side and the pin driver.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps

interface pa_mux_if;
  import pa_pkg::*;

  pa_mode_t mode;
  logic     port_do;
  logic     port_dir;
  logic     cs0;
  logic     rd;
  logic     sck_o;
  logic     sck_oe;
  logic     pin_do;
  logic     pin_oe_n;

  modport ctl (
    output mode, port_do, port_dir, cs0, rd, sck_o, sck_oe,
    input  pin_do, pin_oe_n
  );

  modport mux (
    input  mode, port_do, port_dir, cs0, rd, sck_o, sck_oe,
    output pin_do, pin_oe_n
  );
endinterface

// File: rtl/pa_mux.sv
/*
  Pin driver: registers the pin level and output enable per mode.
  Assumes the mode and sources are on the system clock.
*/
`timescale 1ns/1ps
`include "pa_defines.svh"

module pa_mux
  import pa_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  pa_mux_if.mux    bus
);

  pa_mux_st_t st_q;
  pa_mux_st_t st_d;

  always_comb
  begin
    st_d          = st_q;
    st_d.pin_do   = 1'b0;
    st_d.pin_oe_n = 1'b1;
    unique case (bus.mode)
      `PA_MODE_PORT:
      begin
        st_d.pin_do   = bus.port_do;
        st_d.pin_oe_n = ~bus.port_dir;
      end
      `PA_MODE_CS0:
      begin
        st_d.pin_do   = bus.cs0;
        st_d.pin_oe_n = 1'b0;
      end
      `PA_MODE_RD:
      begin
        st_d.pin_do   = bus.rd;
        st_d.pin_oe_n = 1'b0;
      end
      `PA_MODE_TCK:
      begin
        st_d.pin_oe_n = 1'b1;
      end
      `PA_MODE_SERIAL_CH2_CLOCK:
      begin
        st_d.pin_do   = bus.sck_o;
        st_d.pin_oe_n = ~bus.sck_oe;
      end
      default:
      begin
        st_d.pin_oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q <= '{pin_do: 1'b0, pin_oe_n: 1'b1};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign bus.pin_do   = st_q.pin_do;
  assign bus.pin_oe_n = st_q.pin_oe_n;

  a_port_drive: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (bus.mode == `PA_MODE_PORT)
      |=> (bus.pin_oe_n == !$past(bus.port_dir))
          && (bus.pin_do == $past(bus.port_do)))
    else $error("Port mode pin drive wrong");

  a_cs0_drive: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (bus.mode == `PA_MODE_CS0)
      |=> !bus.pin_oe_n && (bus.pin_do == $past(bus.cs0)))
    else $error("Chip select not on pin");

  a_tck_release: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (bus.mode == `PA_MODE_TCK) [*2] |-> bus.pin_oe_n)
    else $error("Pin driven in test clock mode");

  a_rd_drive: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (bus.mode == `PA_MODE_RD)
      |=> !bus.pin_oe_n && (bus.pin_do == $past(bus.rd)))
    else $error("Read strobe not on pin");

endmodule

// File: rtl/pa_top.sv
/*
  Function select for shared pin 10 of port A, with control registers.
  Assumes a single-cycle strobe register port on the system clock and
  an external pad that resolves the pin from level and enable.
*/
`timescale 1ns/1ps
`include "pa_defines.svh"

// Functional notes
// - Mode is 3 bits: ctrl3 bit 10 high, ctrl1 bits 5..4 low
// - Mode 000 makes the pin a bidirectional port bit
// - Mode 001 drives the pin with bus chip select 0
// - Mode 100 routes the pin to the debug test clock input
module pa_top
  import pa_pkg::*;
(
  input  wire logic                  SYS_CLK_I,
  input  wire logic                  SYS_RST_I,
  input  wire logic [`PA_ADDR_W-1:0] REG_ADDR_I,
  input  wire logic [`PA_DATA_W-1:0] REG_WDATA_I,
  input  wire logic                  REG_WR_I,
  input  wire logic                  REG_RD_I,
  output logic      [`PA_DATA_W-1:0] REG_RDATA_O,
  input  wire logic                  PIN_I,
  output logic                       PIN_O,
  output logic                       PIN_OE_N_O,
  input  wire logic                  CS0_I,
  input  wire logic                  RD_STROBE_I,
  input  wire logic                  SERIAL_CH2_CLOCK_I,
  input  wire logic                  SERIAL_CH2_CLOCK_OE_I,
  output logic                       SERIAL_CH2_CLOCK_O,
  output logic                       TCK_O
);

  pa_top_st_t st_q;
  pa_top_st_t st_d;
  pa_mode_t   mode;
  pa_mux_if   mux_bus ();

  function automatic pa_mode_t get_mode(
    input logic [`PA_DATA_W-1:0] c1,
    input logic [`PA_DATA_W-1:0] c3
  );
    get_mode = {c3[`PA_MD_HI_BIT], c1[`PA_MD_LO_MSB:`PA_MD_LO_LSB]};
  endfunction

  assign mode = get_mode(st_q.ctrl1, st_q.ctrl3);

  always_comb
  begin
    st_d       = st_q;
    st_d.rdata = `PA_RST_REG;
    // Three-stage sampler, level taken when stages two and three agree
    st_d.sync  = {st_q.sync[1:0], PIN_I};
    if (st_q.sync[1] == st_q.sync[2])
    begin
      st_d.pin_f = st_q.sync[2];
    end
    if (REG_WR_I)
    begin
      unique case (REG_ADDR_I)
        `PA_ADDR_CTRL1: st_d.ctrl1 = REG_WDATA_I;
        `PA_ADDR_CTRL3: st_d.ctrl3 = REG_WDATA_I;
        `PA_ADDR_PDATA: st_d.port_do = REG_WDATA_I[`PA_PBIT];
        `PA_ADDR_PDIR:  st_d.port_dir = REG_WDATA_I[`PA_PBIT];
        default:        st_d.rdata = `PA_RST_REG;
      endcase
    end
    if (REG_RD_I)
    begin
      unique case (REG_ADDR_I)
        `PA_ADDR_CTRL1: st_d.rdata = st_q.ctrl1;
        `PA_ADDR_CTRL3: st_d.rdata = st_q.ctrl3;
        `PA_ADDR_PDATA: st_d.rdata[`PA_PBIT] = st_q.port_do;
        `PA_ADDR_PDIR:  st_d.rdata[`PA_PBIT] = st_q.port_dir;
        `PA_ADDR_STAT:
        begin
          st_d.rdata[`PA_ST_LVL] = st_q.pin_f;
          st_d.rdata[`PA_ST_MD_MSB:`PA_ST_MD_LSB] = mode;
        end
        default:        st_d.rdata = `PA_RST_REG;
      endcase
    end
    st_d.tck    = (mode == `PA_MODE_TCK) && st_q.pin_f;
    st_d.sck_in = (mode == `PA_MODE_SERIAL_CH2_CLOCK) && st_q.pin_f;
  end

  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      st_q <= '{ctrl1: `PA_RST_REG, ctrl3: `PA_RST_REG,
                port_do: 1'b0, port_dir: 1'b0,
                sync: `PA_RST_SYNC, pin_f: 1'b0,
                rdata: `PA_RST_REG, tck: 1'b0, sck_in: 1'b0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign mux_bus.mode     = mode;
  assign mux_bus.port_do  = st_q.port_do;
  assign mux_bus.port_dir = st_q.port_dir;
  assign mux_bus.cs0      = CS0_I;
  assign mux_bus.rd       = RD_STROBE_I;
  assign mux_bus.sck_o    = SERIAL_CH2_CLOCK_I;
  assign mux_bus.sck_oe   = SERIAL_CH2_CLOCK_OE_I;

  pa_mux u_mux (
    .clk_i (SYS_CLK_I),
    .rst_i (SYS_RST_I),
    .bus   (mux_bus.mux)
  );

  assign PIN_O       = mux_bus.pin_do;
  assign PIN_OE_N_O  = mux_bus.pin_oe_n;
  assign REG_RDATA_O = st_q.rdata;
  assign TCK_O       = st_q.tck;
  assign SERIAL_CH2_CLOCK_O      = st_q.sck_in;

  a_reset_mode: assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    $past(SYS_RST_I) |-> (mode == `PA_MODE_PORT) && PIN_OE_N_O)
    else $error("Mode not port after reset");

  a_mode_split: assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (REG_WR_I && (REG_ADDR_I == `PA_ADDR_CTRL3))
      |=> mode[2] == $past(REG_WDATA_I[`PA_MD_HI_BIT]))
    else $error("Mode high bit not from ctrl3");

  a_mode_low: assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (REG_WR_I && (REG_ADDR_I == `PA_ADDR_CTRL1))
      |=> mode[1:0] == $past(REG_WDATA_I[`PA_MD_LO_MSB:`PA_MD_LO_LSB]))
    else $error("Mode low bits not from ctrl1");

  a_tck_route: assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (mode == `PA_MODE_TCK) |=> TCK_O == $past(st_q.pin_f))
    else $error("Test clock not routed");

  a_tck_gated: assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (mode != `PA_MODE_TCK) |=> !TCK_O)
    else $error("Test clock leaks in other mode");

  a_read_ctrl: assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (REG_RD_I && (REG_ADDR_I == `PA_ADDR_STAT))
      |=> REG_RDATA_O[`PA_ST_MD_MSB:`PA_ST_MD_LSB] == $past(mode))
    else $error("Status mode readback wrong");

  a_sck_route: assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (mode == `PA_MODE_SERIAL_CH2_CLOCK) ##1 (mode == `PA_MODE_SERIAL_CH2_CLOCK)
      |-> PIN_OE_N_O == !$past(SERIAL_CH2_CLOCK_OE_I))
    else $error("Serial clock enable not on pin");

  a_sck_gated: assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (mode != `PA_MODE_SERIAL_CH2_CLOCK) |=> !SERIAL_CH2_CLOCK_O)
    else $error("Serial clock leaks in other mode");

  a_sck_sense: assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (mode == `PA_MODE_SERIAL_CH2_CLOCK) |=> SERIAL_CH2_CLOCK_O == $past(st_q.pin_f))
    else $error("Serial clock input not routed");

  a_bad_release: assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    !(mode inside {`PA_MODE_PORT, `PA_MODE_CS0, `PA_MODE_RD,
                   `PA_MODE_TCK, `PA_MODE_SERIAL_CH2_CLOCK})
      |=> PIN_OE_N_O && !PIN_O)
    else $error("Pin driven in prohibited mode");

  a_pin_filter: assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (st_q.sync[1] == st_q.sync[2])
      |=> st_q.pin_f == $past(st_q.sync[2]))
    else $error("Filtered level not taken on agree");

  a_pin_hold: assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (st_q.sync[1] != st_q.sync[2]) |=> $stable(st_q.pin_f))
    else $error("Filtered level moved without agree");

  a_stat_level: assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (REG_RD_I && (REG_ADDR_I == `PA_ADDR_STAT))
      |=> REG_RDATA_O[`PA_ST_LVL] == $past(st_q.pin_f))
    else $error("Status level readback wrong");

  a_dir_write: assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (REG_WR_I && (REG_ADDR_I == `PA_ADDR_PDIR))
      |=> st_q.port_dir == $past(REG_WDATA_I[`PA_PBIT]))
    else $error("Port direction write lost");

  a_reset_regs: assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    $past(SYS_RST_I) |-> (st_q.ctrl1 == `PA_RST_REG)
      && (st_q.ctrl3 == `PA_RST_REG) && !TCK_O && !SERIAL_CH2_CLOCK_O && !PIN_O)
    else $error("Registers not cleared by reset");

  a_ctrl1_read: assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (REG_RD_I && (REG_ADDR_I == `PA_ADDR_CTRL1))
      |=> REG_RDATA_O == $past(st_q.ctrl1))
    else $error("Control 1 readback wrong");

  a_ctrl3_read: assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (REG_RD_I && (REG_ADDR_I == `PA_ADDR_CTRL3))
      |=> REG_RDATA_O == $past(st_q.ctrl3))
    else $error("Control 3 readback wrong");

  a_rdata_idle: assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    !$past(REG_RD_I) |-> REG_RDATA_O == `PA_RST_REG)
    else $error("Read data not zero outside read");

  a_unmapped_wr: assert property (
    @(posedge SYS_CLK_I) disable iff (SYS_RST_I)
    (REG_WR_I && (REG_ADDR_I > `PA_ADDR_STAT))
      |=> $stable(st_q.ctrl1) && $stable(st_q.ctrl3)
          && $stable(st_q.port_do) && $stable(st_q.port_dir))
    else $error("Unmapped write changed a register");

endmodule

// File: verif/pa_pad_model.sv
/*
  Pad and far-side driver model for shared pin 10.
  Assumes the bench drives ext_en_i and ext_lvl_i after the clock edge.
*/
`timescale 1ns/1ps

module pa_pad_model
(
  input  wire logic clk_i,
  input  wire logic pin_i,
  input  wire logic oe_n_i,
  input  wire logic ext_en_i,
  input  wire logic ext_lvl_i,
  output logic      pad_o
);
  logic flt_q = 1'b0;

  // Undriven pad has no pull, so it wanders
  always @(posedge clk_i)
    flt_q <= ~flt_q;

  assign pad_o = !oe_n_i ? pin_i : (ext_en_i ? ext_lvl_i : flt_q);
endmodule

// File: verif/pa_top_tb.sv
/*
  Self-checking bench for the shared pin 10 function select.
  Assumes the design files are compiled first.
*/
`timescale 1ns/1ps
`include "pa_defines.svh"

module pa_top_tb
  import pa_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        cs0 = 1'b0;
  logic        rds = 1'b0;
  logic        sck = 1'b0;
  logic        sck_oe = 1'b0;
  logic        ext_en = 1'b0;
  logic        ext_lvl = 1'b0;
  logic [15:0] rdata;
  logic [15:0] v;
  logic        pad;
  logic        pin_o;
  logic        oe_n;
  logic        serial_ch2_clock_o;
  logic        tck_o;
  pa_mode_t    m;
  pa_mode_t    codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h3};
  int          err_count = 0;
  int          comparisons = 0;

  always #50 clk = ~clk;

  pa_top dut_u (.SYS_CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_RDATA_O(rdata), .PIN_I(pad), .PIN_O(pin_o), .PIN_OE_N_O(oe_n),
    .CS0_I(cs0), .RD_STROBE_I(rds), .SERIAL_CH2_CLOCK_I(sck), .SERIAL_CH2_CLOCK_OE_I(sck_oe),
    .SERIAL_CH2_CLOCK_O(serial_ch2_clock_o), .TCK_O(tck_o));

  pa_pad_model pad_u (.clk_i(clk), .pin_i(pin_o), .oe_n_i(oe_n),
    .ext_en_i(ext_en), .ext_lvl_i(ext_lvl), .pad_o(pad));

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic set_mode(input pa_mode_t md);
    wr_reg(`PA_ADDR_CTRL1, {10'h000, md[1:0], 4'h0});
    wr_reg(`PA_ADDR_CTRL3, {5'h00, md[2], 10'h000});
    step(3);
  endtask

  task automatic pin_chk(input logic lvl, input logic oen);
    chk("pin level", {15'h0, pin_o}, {15'h0, lvl});
    chk("pin oe_n", {15'h0, oe_n}, {15'h0, oen});
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #1000000;
    err_count++;
    final_report();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`PA_ADDR_CTRL1, v);
    chk("ctrl1 reset", v, 16'h0000);
    rd_reg(`PA_ADDR_CTRL3, v);
    chk("ctrl3 reset", v, 16'h0000);
    rd_reg(`PA_ADDR_STAT, v);
    chk("mode reset", {13'h0, v[3:1]}, 16'h0000);
    chk("oe_n reset", {15'h0, oe_n}, 16'h0001);
    $display("reset test done");
    wr_reg(`PA_ADDR_PDIR, 16'h0001);
    wr_reg(`PA_ADDR_PDATA, 16'h0001);
    step(3);
    pin_chk(1'b1, 1'b0);
    wr_reg(`PA_ADDR_PDATA, 16'h0000);
    step(3);
    pin_chk(1'b0, 1'b0);
    wr_reg(`PA_ADDR_PDIR, 16'h0000);
    ext_en  <= 1'b1;
    ext_lvl <= 1'b1;
    step(8);
    rd_reg(`PA_ADDR_STAT, v);
    chk("port input", {15'h0, v[0]}, 16'h0001);
    $display("port test done");
    foreach (codes[i])
    begin
      m = codes[i];
      set_mode(m);
      rd_reg(`PA_ADDR_STAT, v);
      chk("mode field", {13'h0, v[3:1]}, {13'h0, m});
      @(posedge clk);
      cs0 <= (m == 3'h1);
      rds <= (m == 3'h2);
      sck <= 1'b1;
      sck_oe <= 1'b1;
      ext_lvl <= 1'b0;
      step(8);
      if (m == 3'h1)
        pin_chk(1'b1, 1'b0);
      if (m == 3'h2)
        pin_chk(1'b1, 1'b0);
      if (m == 3'h5)
        pin_chk(1'b1, 1'b0);
      if (m == 3'h4)
        chk("tck low", {15'h0, tck_o}, 16'h0000);
      if (m == 3'h3)
        pin_chk(1'b0, 1'b1);
      @(posedge clk);
      cs0 <= 1'b0;
      rds <= 1'b0;
      sck_oe <= 1'b0;
      ext_lvl <= 1'b1;
      step(8);
      if (m == 3'h1 || m == 3'h2)
        pin_chk(1'b0, 1'b0);
      if (m == 3'h4 || m == 3'h5)
        chk("oe_n input", {15'h0, oe_n}, 16'h0001);
      chk("tck", {15'h0, tck_o}, {15'h0, m == 3'h4});
      chk("serial_ch2_clock", {15'h0, serial_ch2_clock_o}, {15'h0, m == 3'h5});
    end
    $display("mode test done");
    wr_reg(`PA_ADDR_CTRL1, 16'hffcf);
    wr_reg(`PA_ADDR_CTRL3, 16'h0400);
    wr_reg(3'h5, 16'hffff);
    rd_reg(`PA_ADDR_CTRL1, v);
    chk("ctrl1 rw", v, 16'hffcf);
    rd_reg(`PA_ADDR_CTRL3, v);
    chk("ctrl3 rw", v, 16'h0400);
    rd_reg(`PA_ADDR_STAT, v);
    chk("mode hi bit", {13'h0, v[3:1]}, 16'h0004);
    rd_reg(3'h5, v);
    chk("unmapped", v, 16'h0000);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`PA_ADDR_CTRL3, v);
    chk("ctrl3 rereset", v, 16'h0000);
    rd_reg(`PA_ADDR_STAT, v);
    chk("mode rereset", {13'h0, v[3:1]}, 16'h0000);
    chk("oe_n rereset", {15'h0, oe_n}, 16'h0001);
    $display("register test done");
    final_report();
  end
endmodule
